// ===== hdl/dpsb_pkg.sv
/*
  Shared constants and types of the double-precision source scoreboard:
  opcode classes, execute phases and every stage count but the tail start stage 2, which is set in the control.
  Assumes: one core clock; single-precision register space of 32 entries,
  a double register d covers singles 2d and 2d+1.
*/
package dpsb_pkg;

  localparam int REG_COUNT = 32;
  localparam int VLEN_WIDTH = 3;

  // first iteration (1-based) that still locks sources in fast no-trap mode
  localparam logic [3:0] FAST_FIRST_DOUBLE = 4'h3;
  localparam logic [3:0] FAST_FIRST_SINGLE = 4'h5;
  // last execute stage of the multiply-add pipeline, where destinations unlock
  localparam logic [2:0] EXEC_LAST_STAGE = 3'h7;
  // execute stages a compare needs before the condition codes are updated
  localparam logic [2:0] CMP_EXEC_CYCLES = 3'h4;
  // cycles from leaving decode to delivering flags to the host
  localparam logic [1:0] FLAG_DELIVER_CYCLES = 2'h2;
  // execute, memory 1 and memory 2 before the first load writeback
  localparam logic [1:0] LDM_PRE_STAGES = 2'h3;
  localparam logic [5:0] LDM_REGS_PER_WB = 6'h02;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_DOUBLE_ADD = 4'h1,
    OP_DOUBLE_ABSOLUTE = 4'h2,
    OP_DOUBLE_MULTIPLY = 4'h3,
    OP_DOUBLE_MULTIPLY_ACCUMULATE = 4'h4,
    OP_SINGLE_ADD = 4'h5,
    OP_SINGLE_COMPARE = 4'h6,
    OP_LOAD_MULTIPLE = 4'h7,
    OP_MOVE_FLAGS_TO_HOST = 4'h8
  } dpsb_op_t;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b00,
    EX_E1 = 2'b01,
    EX_TAIL = 2'b10
  } dpsb_ex_phase_t;

endpackage : dpsb_pkg

// ===== hdl/dpsb_lock_if.sv
/*
  Carrier between the scoreboard control and its lock store.
  Assumes: both ends on clk_sys; set and clear masks are one-cycle values.
*/
`timescale 1ns/1ns
`default_nettype none
interface dpsb_lock_if;
  logic [31:0] setSrc;
  logic [31:0] clrSrc;
  logic [31:0] setDst;
  logic [31:0] clrDst;
  logic [31:0] srcLock;
  logic [31:0] dstLock;
  modport ctrl (output setSrc, output clrSrc, output setDst, output clrDst, input srcLock, input dstLock);
  modport store (input setSrc, input clrSrc, input setDst, input clrDst, output srcLock, output dstLock);
endinterface : dpsb_lock_if
`default_nettype wire

// ===== hdl/dpsb_lock_store.sv
/*
  Source and destination lock bits, one per single-precision register.
  Assumes: masks come from the control on the same clock; lock outputs are
  read straight from the registers.
*/
`timescale 1ns/1ns
`default_nettype none
module dpsb_lock_store (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  dpsb_lock_if.store lk
);
  import dpsb_pkg::*;

  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
  } dpsb_store_t;

  dpsb_store_t st_reg;
  dpsb_store_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // a set in the same cycle as a clear wins, so a fresh lock is never lost
  always_comb begin
    st_next = st_reg;
    if (clkEn) begin
      st_next.src = (st_reg.src & ~lk.clrSrc) | lk.setSrc;
      st_next.dst = (st_reg.dst & ~lk.clrDst) | lk.setDst;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign lk.srcLock = st_reg.src;
  assign lk.dstLock = st_reg.dst;

  ////////////////////////////////////////////////////////////////////////////
  property p_setWins;
    @(posedge clk_sys) disable iff (!resetn)
    (clkEn && lk.setSrc != 32'h0) |=> ((lk.srcLock & $past(lk.setSrc)) == $past(lk.setSrc));
  endproperty
  a_setWins: assert property (p_setWins) else $error("source lock set was lost");

endmodule : dpsb_lock_store
`default_nettype wire

// ===== hdl/dpsb_scoreboard.sv
/*
  Source scoreboard control of a coprocessor arithmetic pipeline: issue hazard
  check, source and destination locking, per-iteration source release in
  Execute 1, compare to flag-transfer hold and load multiple writeback.
  Assumes: the host presents one instruction at a time on issueValid and
  holds it until issueReady; all inputs come from logic on clk_sys.
*/
// Function
// - full-compliance: lock sources of every iteration when leaving Issue
// - fast no-trap: lock only iterations three and four of double vectors
// - low two bits of the vector length field plus one give the double iteration count
// - fast: length three locks iteration three, four locks three and four
// - one-cycle full: iteration k sources release in Execute 1 cycle k
// - one-cycle fast: iteration three releases in cycle one, four in two
// - two-cycle full: iterations release in Execute 1 cycles 1, 3, 5, 7
// - two-cycle fast: iteration three releases in cycle one, four in three
// - double multiply and multiply-accumulate are two-cycle; add, absolute one-cycle
// - flag transfer held in Decode until compare updates condition codes
// - flags reach the host two cycles after the transfer leaves Decode
// - add waits in Issue for last load transfer, forwarded same cycle
// - issue only when no source or destination of any iteration is locked, except a lock that load writeback drops that cycle
// - on a hazard no lock is set and the instruction waits in Issue
// - multiply-add pipeline destination lock releases in Execute 7
`timescale 1ns/1ns
`default_nettype none
module dpsb_scoreboard (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clkEn,
  input wire logic fastNoTrapMode,
  input wire logic [dpsb_pkg::VLEN_WIDTH-1:0] vectorLengthField,
  input wire logic issueValid,
  input wire dpsb_pkg::dpsb_op_t issueOp,
  input wire logic [4:0] srcA,
  input wire logic [4:0] srcB,
  input wire logic [4:0] dst,
  input wire logic [5:0] loadCount,
  input wire logic [3:0] compareFlags,
  output logic issueReady,
  output logic forwardHit,
  output logic [3:0] hostFlags,
  output logic hostFlagsValid,
  output logic [31:0] srcLockOut,
  output logic [31:0] dstLockOut
);
  import dpsb_pkg::*;

  typedef struct packed {
    dpsb_ex_phase_t exPhase;
    logic [3:0] e1Cnt;
    logic [2:0] stageCnt;
    logic exDouble;
    logic exTwoCycle;
    logic exFast;
    logic [3:0] exIter;
    logic [4:0] exSrcA;
    logic [4:0] exSrcB;
    logic [4:0] exDst;
    logic ldActive;
    logic [1:0] ldPre;
    logic [4:0] ldNext;
    logic [5:0] ldLeft;
    logic [2:0] cmpCnt;
    logic [3:0] ccReg;
    logic [1:0] mvfCnt;
    logic [3:0] hostFlags;
    logic hostFlagsValid;
  } dpsb_state_t;

  dpsb_state_t st_reg;
  dpsb_state_t st_next;
  dpsb_lock_if lk ();

  ////////////////////////////////////////////////////////////////////////////
  // register mask of one iteration; a double covers two singles
  function automatic logic [31:0] iterMask(input logic isDbl, input logic [4:0] base, input logic [3:0] k);
    logic [4:0] idx;
    logic [31:0] m;
    m = '0;
    idx = base + {1'b0, k};
    if (isDbl) begin
      m[{idx[3:0], 1'b0}] = 1'b1;
      m[{idx[3:0], 1'b1}] = 1'b1;
    end else begin
      m[idx] = 1'b1;
    end
    return m;
  endfunction : iterMask

  // union of iterations first..n-1 (0-based)
  function automatic logic [31:0] spanMask(input logic isDbl, input logic [4:0] base, input logic [3:0] first,
                                          input logic [3:0] n);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) >= first && 4'(i) < n) begin
        m = m | iterMask(isDbl, base, 4'(i));
      end
    end
    return m;
  endfunction : spanMask

  // consecutive singles of a load multiple
  function automatic logic [31:0] rangeMask(input logic [4:0] base, input logic [5:0] n);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < REG_COUNT; i++) begin
      if (6'(i) < n) begin
        m[base + 5'(i)] = 1'b1;
      end
    end
    return m;
  endfunction : rangeMask

  ////////////////////////////////////////////////////////////////////////////
  // decode of the presented instruction
  logic isArith;
  logic isDbl;
  logic twoCycle;
  logic isMac;
  logic [3:0] nIter;
  logic [3:0] lockFirst;
  logic [31:0] needMask;
  logic [31:0] srcAll;
  logic [31:0] srcSetMask;
  logic [31:0] dstSetMask;
  logic [31:0] ldClr;
  logic [31:0] busyMask;
  logic hazard;
  logic accept;
  logic [31:0] exClr;
  logic [3:0] clrIter;
  logic [3:0] e1Last;

  always_comb begin
    isDbl = issueOp inside {OP_DOUBLE_ADD, OP_DOUBLE_ABSOLUTE, OP_DOUBLE_MULTIPLY, OP_DOUBLE_MULTIPLY_ACCUMULATE};
    isArith = isDbl || issueOp == OP_SINGLE_ADD;
    twoCycle = issueOp inside {OP_DOUBLE_MULTIPLY, OP_DOUBLE_MULTIPLY_ACCUMULATE};
    isMac = issueOp == OP_DOUBLE_MULTIPLY_ACCUMULATE;
    nIter = isDbl ? {2'b00, vectorLengthField[1:0]} + 4'h1 : {1'b0, vectorLengthField} + 4'h1;
    lockFirst = 4'h0;
    if (fastNoTrapMode) begin
      lockFirst = (isDbl ? FAST_FIRST_DOUBLE : FAST_FIRST_SINGLE) - 4'h1;
    end
  end

  // masks over all iterations, source locks from lockFirst on; in full-compliance mode a MAC preserves its accumulator too
  always_comb begin
    srcAll = spanMask(isDbl, srcA, 4'h0, nIter) | spanMask(isDbl, srcB, 4'h0, nIter);
    srcSetMask = '0;
    dstSetMask = '0;
    needMask = '0;
    if (isArith) begin
      needMask = srcAll | spanMask(isDbl, dst, 4'h0, nIter);
      srcSetMask = spanMask(isDbl, srcA, lockFirst, nIter) | spanMask(isDbl, srcB, lockFirst, nIter);
      if (isMac && !fastNoTrapMode) begin
        srcSetMask = srcSetMask | spanMask(isDbl, dst, 4'h0, nIter);
      end
      dstSetMask = spanMask(isDbl, dst, 4'h0, nIter);
    end else if (issueOp == OP_LOAD_MULTIPLE) begin
      needMask = rangeMask(dst, loadCount);
      dstSetMask = needMask;
    end else if (issueOp == OP_SINGLE_COMPARE) begin
      needMask = iterMask(1'b0, srcA, 4'h0) | iterMask(1'b0, srcB, 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load writeback clears up to two singles; those registers forward now
  always_comb begin
    ldClr = '0;
    if (st_reg.ldActive && st_reg.ldPre == 2'h0) begin
      ldClr = rangeMask(st_reg.ldNext, (st_reg.ldLeft < LDM_REGS_PER_WB) ? st_reg.ldLeft : LDM_REGS_PER_WB);
    end
  end

  // a lock dropping this cycle through load writeback counts as free
  assign busyMask = (lk.srcLock | lk.dstLock) & ~ldClr;

  always_comb begin
    hazard = (needMask & busyMask) != 32'h0;
    if (isArith && st_reg.exPhase != EX_IDLE) begin
      hazard = 1'b1; // one arithmetic op in flight keeps the clear schedule exact
    end
    if (issueOp == OP_LOAD_MULTIPLE && (st_reg.ldActive || loadCount == 6'h00)) begin
      hazard = 1'b1;
    end
    if (issueOp == OP_MOVE_FLAGS_TO_HOST && (st_reg.cmpCnt > 3'h1 || st_reg.mvfCnt != 2'h0)) begin
      hazard = 1'b1;
    end
    if (issueOp == OP_NONE) begin
      hazard = 1'b1;
    end
  end

  // frozen clock enable also refuses new work
  assign issueReady = clkEn && !hazard;
  assign accept = issueValid && issueReady;
  assign forwardHit = accept && ((needMask & lk.dstLock & ldClr) != 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // which iteration releases its sources in the current Execute 1 cycle
  always_comb begin
    exClr = '0;
    clrIter = (st_reg.exTwoCycle ? (st_reg.e1Cnt - 4'h1) >> 1 : st_reg.e1Cnt - 4'h1)
              + (st_reg.exFast ? (st_reg.exDouble ? FAST_FIRST_DOUBLE : FAST_FIRST_SINGLE) - 4'h1 : 4'h0);
    e1Last = st_reg.exTwoCycle ? {st_reg.exIter[2:0], 1'b0} : st_reg.exIter;
    if (st_reg.exPhase == EX_E1 && !(st_reg.exTwoCycle && !st_reg.e1Cnt[0]) && clrIter < st_reg.exIter) begin
      exClr = iterMask(st_reg.exDouble, st_reg.exSrcA, clrIter) | iterMask(st_reg.exDouble, st_reg.exSrcB, clrIter);
      if (st_reg.exFast == 1'b0 && st_reg.exTwoCycle && st_reg.exDouble) begin
        exClr = exClr | iterMask(1'b1, st_reg.exDst, clrIter);
      end
    end
  end

  always_comb begin
    lk.setSrc = (accept && isArith) ? srcSetMask : 32'h0;
    lk.setDst = accept ? dstSetMask : 32'h0;
    lk.clrSrc = exClr;
    lk.clrDst = ldClr;
    if (st_reg.exPhase == EX_TAIL && st_reg.stageCnt == EXEC_LAST_STAGE) begin
      lk.clrDst = ldClr | spanMask(st_reg.exDouble, st_reg.exDst, 4'h0, st_reg.exIter);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pipeline sequencing: execute phases, load stages, compare and flags
  always_comb begin
    st_next = st_reg;
    if (clkEn) begin
      st_next.hostFlagsValid = 1'b0; // the pulse freezes with the rest of the state
      case (st_reg.exPhase)
        EX_IDLE: begin
          if (accept && isArith) begin
            st_next.exPhase = EX_E1;
            st_next.e1Cnt = 4'h1;
            st_next.exDouble = isDbl;
            st_next.exTwoCycle = twoCycle;
            st_next.exFast = fastNoTrapMode;
            st_next.exIter = nIter;
            st_next.exSrcA = srcA;
            st_next.exSrcB = srcB;
            st_next.exDst = dst;
          end
        end
        EX_E1: begin
          st_next.e1Cnt = st_reg.e1Cnt + 4'h1;
          if (st_reg.e1Cnt == e1Last) begin
            st_next.exPhase = EX_TAIL;
            st_next.stageCnt = 3'h2;
          end
        end
        EX_TAIL: begin
          st_next.stageCnt = st_reg.stageCnt + 3'h1;
          if (st_reg.stageCnt == EXEC_LAST_STAGE) begin
            st_next.exPhase = EX_IDLE;
          end
        end
        default: begin
          st_next.exPhase = EX_IDLE;
        end
      endcase
      if (accept && issueOp == OP_LOAD_MULTIPLE) begin
        st_next.ldActive = 1'b1;
        st_next.ldPre = LDM_PRE_STAGES;
        st_next.ldNext = dst;
        st_next.ldLeft = loadCount;
      end else if (st_reg.ldActive && st_reg.ldPre != 2'h0) begin
        st_next.ldPre = st_reg.ldPre - 2'h1;
      end else if (st_reg.ldActive) begin
        st_next.ldNext = st_reg.ldNext + 5'h02;
        st_next.ldLeft = (st_reg.ldLeft > LDM_REGS_PER_WB) ? st_reg.ldLeft - LDM_REGS_PER_WB : 6'h00;
        st_next.ldActive = st_reg.ldLeft > LDM_REGS_PER_WB;
      end
      if (st_reg.cmpCnt != 3'h0) begin
        st_next.cmpCnt = st_reg.cmpCnt - 3'h1;
      end
      if (st_reg.cmpCnt == 3'h1) begin
        st_next.ccReg = compareFlags; // condition codes land in the last compare stage
      end
      if (accept && issueOp == OP_SINGLE_COMPARE) begin
        st_next.cmpCnt = CMP_EXEC_CYCLES;
      end
      if (st_reg.mvfCnt != 2'h0) begin
        st_next.mvfCnt = st_reg.mvfCnt - 2'h1;
      end
      if (st_reg.mvfCnt == 2'h1) begin
        st_next.hostFlags = st_reg.ccReg;
        st_next.hostFlagsValid = 1'b1;
      end
      if (accept && issueOp == OP_MOVE_FLAGS_TO_HOST) begin
        st_next.mvfCnt = FLAG_DELIVER_CYCLES - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  dpsb_lock_store u_store (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clkEn(clkEn),
    .lk(lk)
  );

  assign hostFlags = st_reg.hostFlags;
  assign hostFlagsValid = st_reg.hostFlagsValid;
  assign srcLockOut = lk.srcLock;
  assign dstLockOut = lk.dstLock;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  property p_fullLock;
    (accept && isDbl && !fastNoTrapMode) |=> ((lk.srcLock & $past(srcAll)) == $past(srcAll));
  endproperty
  a_fullLock: assert property (p_fullLock) else $error("full mode left a source unlocked");

  property p_fastShort;
    (accept && isDbl && fastNoTrapMode && vectorLengthField[1:0] < 2'h2) |-> lk.setSrc == 32'h0;
  endproperty
  a_fastShort: assert property (p_fastShort) else $error("short fast vector locked sources");

  property p_fastThree;
    (accept && isDbl && fastNoTrapMode && vectorLengthField[1:0] == 2'h2)
      |-> lk.setSrc == (iterMask(1'b1, srcA, 4'h2) | iterMask(1'b1, srcB, 4'h2));
  endproperty
  a_fastThree: assert property (p_fastThree) else $error("length three fast lock wrong");

  property p_oneCycleClr;
    (st_reg.exPhase == EX_E1 && st_reg.exDouble && !st_reg.exTwoCycle && !st_reg.exFast)
      |-> lk.clrSrc == (iterMask(1'b1, st_reg.exSrcA, st_reg.e1Cnt - 4'h1)
                        | iterMask(1'b1, st_reg.exSrcB, st_reg.e1Cnt - 4'h1));
  endproperty
  a_oneCycleClr: assert property (p_oneCycleClr) else $error("one-cycle release off schedule");

  property p_twoCycleGap;
    (st_reg.exPhase == EX_E1 && st_reg.exTwoCycle && !st_reg.e1Cnt[0]) |-> lk.clrSrc == 32'h0;
  endproperty
  a_twoCycleGap: assert property (p_twoCycleGap) else $error("release in second half of two-cycle iteration");

  property p_fastClrSeq;
    (clkEn && st_reg.exPhase == EX_IDLE && accept && isDbl && !twoCycle && fastNoTrapMode
      && vectorLengthField[1:0] == 2'h3) ##1 clkEn
      |-> lk.clrSrc == (iterMask(1'b1, st_reg.exSrcA, 4'h2) | iterMask(1'b1, st_reg.exSrcB, 4'h2))
      ##1 (!clkEn || lk.clrSrc == (iterMask(1'b1, st_reg.exSrcA, 4'h3) | iterMask(1'b1, st_reg.exSrcB, 4'h3)));
  endproperty
  a_fastClrSeq: assert property (p_fastClrSeq) else $error("fast one-cycle release order wrong");

  property p_flagHold;
    (accept && issueOp == OP_MOVE_FLAGS_TO_HOST) |-> st_reg.cmpCnt <= 3'h1;
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag transfer left decode before codes updated");

  property p_flagDeliver;
    (accept && issueOp == OP_MOVE_FLAGS_TO_HOST) ##1 clkEn |=> hostFlagsValid;
  endproperty
  a_flagDeliver: assert property (p_flagDeliver) else $error("flags not delivered two cycles later");

  property p_noLockOnStall;
    (issueValid && !issueReady) |-> (lk.setSrc == 32'h0 && lk.setDst == 32'h0);
  endproperty
  a_noLockOnStall: assert property (p_noLockOnStall) else $error("stalled instruction changed locks");

  property p_issueFree;
    accept |-> (needMask & busyMask) == 32'h0;
  endproperty
  a_issueFree: assert property (p_issueFree) else $error("issued over a locked register");

  property p_dstRelease;
    (lk.clrDst & ~ldClr) != 32'h0 |-> (st_reg.exPhase == EX_TAIL && st_reg.stageCnt == EXEC_LAST_STAGE);
  endproperty
  a_dstRelease: assert property (p_dstRelease) else $error("destination released outside Execute 7");

endmodule : dpsb_scoreboard
`default_nettype wire

// ===== bench/dpsb_host_model.sv
/*
  Host core model: presents one coprocessor instruction at a time.
  Assumes: tasks are called in the time step of a rising clk_sys edge.
*/
`timescale 1ns/1ns
`default_nettype none
module dpsb_host_model (
  input wire logic clk_sys,
  input wire logic issueReady,
  input wire logic forwardHit,
  output var logic issueValid,
  output var dpsb_pkg::dpsb_op_t issueOp,
  output var logic fastNoTrapMode,
  output var logic [2:0] vectorLengthField,
  output var logic [4:0] srcA,
  output var logic [4:0] srcB,
  output var logic [4:0] dst,
  output var logic [5:0] loadCount
);
  import dpsb_pkg::*;

  initial begin
    issueValid = 1'b0;
    issueOp = OP_NONE;
    {fastNoTrapMode, vectorLengthField, srcA, srcB, dst, loadCount} = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold everything until the edge that saw ready; ready is read mid-cycle
  // so the edge's own updates cannot race the sample
  task automatic issue(input dpsb_op_t op, input logic fast, input logic [2:0] len, input logic [4:0] a,
                       input logic [4:0] b, input logic [4:0] d, input logic [5:0] cnt, input logic keep,
                       output int stalls, output logic fwd, output logic hung);
    logic rdy;
    stalls = 0;
    fwd = 1'b0;
    hung = 1'b1;
    issueValid <= 1'b1;
    issueOp <= op;
    fastNoTrapMode <= fast;
    vectorLengthField <= len;
    {srcA, srcB, dst, loadCount} <= {a, b, d, cnt};
    for (int i = 0; i < 40 && hung; i++) begin
      @(negedge clk_sys);
      rdy = issueReady;
      fwd = forwardHit;
      @(posedge clk_sys);
      if (rdy === 1'b1) hung = 1'b0;
      else stalls++;
    end
    // released register and count fields flip so a stale value cannot pass for a held one;
    // keep leaves the group up for a back-to-back follower to overwrite
    if (!keep) begin
      issueValid <= 1'b0;
      issueOp <= OP_NONE;
      {srcA, srcB, dst, loadCount} <= ~{a, b, d, cnt};
    end
  endtask : issue
endmodule : dpsb_host_model
`default_nettype wire

// ===== bench/dpsb_scoreboard_test.sv
/*
  Self-checking bench of the source scoreboard: row table of double vector
  ops, then hazard, flag transfer and load forwarding cases.
  Assumes: 50 MHz clk_sys; host model drives the issue group.
*/
`timescale 1ns/1ns
`default_nettype none
module dpsb_scoreboard_test;
  import dpsb_pkg::*;

  typedef struct {dpsb_op_t op; logic fast; logic [2:0] len; logic two;} dpsb_row_t;

  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic [3:0] compareFlags = 4'hA;
  logic issueValid, fastNoTrapMode, issueReady, forwardHit, hostFlagsValid;
  dpsb_op_t issueOp;
  logic [2:0] vectorLengthField;
  logic [4:0] srcA, srcB, dst;
  logic [5:0] loadCount;
  logic [3:0] hostFlags;
  logic [31:0] srcLockOut, dstLockOut;
  int n_fail = 0;
  int checked = 0;
  // two marks the expected throughput class of each op
  dpsb_row_t rows [9] = '{'{OP_DOUBLE_ADD, 1'b0, 3'h3, 1'b0}, '{OP_DOUBLE_ABSOLUTE, 1'b0, 3'h1, 1'b0},
    '{OP_DOUBLE_MULTIPLY, 1'b0, 3'h3, 1'b1}, '{OP_DOUBLE_MULTIPLY_ACCUMULATE, 1'b0, 3'h3, 1'b1},
    '{OP_DOUBLE_ADD, 1'b1, 3'h3, 1'b0}, '{OP_DOUBLE_ABSOLUTE, 1'b1, 3'h2, 1'b0},
    '{OP_DOUBLE_MULTIPLY, 1'b1, 3'h3, 1'b1}, '{OP_DOUBLE_ADD, 1'b1, 3'h1, 1'b0},
    '{OP_DOUBLE_MULTIPLY, 1'b1, 3'h0, 1'b1}};

  always #10 clk_sys = ~clk_sys;

  dpsb_scoreboard dpsb_scoreboard_i (.clk_sys(clk_sys), .resetn(resetn), .clkEn(clkEn),
    .fastNoTrapMode(fastNoTrapMode), .vectorLengthField(vectorLengthField), .issueValid(issueValid),
    .issueOp(issueOp), .srcA(srcA), .srcB(srcB), .dst(dst), .loadCount(loadCount),
    .compareFlags(compareFlags), .issueReady(issueReady), .forwardHit(forwardHit), .hostFlags(hostFlags),
    .hostFlagsValid(hostFlagsValid), .srcLockOut(srcLockOut), .dstLockOut(dstLockOut));

  dpsb_host_model dpsb_host_model_i (.clk_sys(clk_sys), .issueReady(issueReady), .forwardHit(forwardHit),
    .issueValid(issueValid), .issueOp(issueOp), .fastNoTrapMode(fastNoTrapMode),
    .vectorLengthField(vectorLengthField), .srcA(srcA), .srcB(srcB), .dst(dst), .loadCount(loadCount));

  ////////////////////////////////////////////////////////////////////////////
  // single-register bits of double d
  function automatic logic [31:0] dbl(input logic [3:0] d);
    return 32'h3 << {d, 1'b0};
  endfunction : dbl

  // source locks still standing t cycles after accept, base doubles 8 and 12
  function automatic logic [31:0] srcExp(input dpsb_row_t r, input int t);
    logic [31:0] m;
    int clr;
    m = '0;
    for (int i = 1; i <= r.len[1:0] + 1; i++) begin
      clr = r.two ? (r.fast ? 2 * i - 5 : 2 * i - 1) : (r.fast ? i - 2 : i);
      if ((!r.fast || i >= 3) && t <= clr) begin
        m |= dbl(4'(7 + i)) | dbl(4'(11 + i));
        if (r.op == OP_DOUBLE_MULTIPLY_ACCUMULATE && !r.fast) m |= dbl(4'(3 + i));
      end
    end
    return m;
  endfunction : srcExp

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  // a hung issue counts as a mismatch and ends the run
  task automatic run(input dpsb_op_t op, input logic fast, input logic [2:0] len, input logic [4:0] a,
                     input logic [4:0] b, input logic [4:0] d, input logic [5:0] cnt, input logic kp,
                     output int st, output logic fw);
    logic hg;
    dpsb_host_model_i.issue(op, fast, len, a, b, d, cnt, kp, st, fw, hg);
    if (hg) begin
      n_fail++;
      summarize();
    end
  endtask : run

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int st, e1, n;
    logic fw;
    repeat (16) @(posedge clk_sys);
    #1;
    chk("locks in reset", 32'h0, srcLockOut | dstLockOut);
    chk("hostFlagsValid in reset", 32'h0, 32'(hostFlagsValid));
    @(posedge clk_sys);
    resetn <= 1'b1;
    // row table: lock set and per-cycle release
    foreach (rows[k]) begin
      @(posedge clk_sys);
      run(rows[k].op, rows[k].fast, rows[k].len, 5'h08, 5'h0C, 5'h04, 6'h01, 1'b0, st, fw);
      n = rows[k].len[1:0] + 1;
      e1 = rows[k].two ? 2 * n : n;
      for (int t = 1; t <= e1 + 7; t++) begin
        #1;
        chk("srcLockOut", srcExp(rows[k], t), srcLockOut);
        chk("dstLockOut", (t <= e1 + 6) ? ((32'h1 << (2 * n)) - 1) << 8 : 32'h0, dstLockOut);
        @(posedge clk_sys);
      end
    end
    // load onto iteration four sources waits for their E1 release
    run(OP_DOUBLE_ADD, 1'b0, 3'h3, 5'h08, 5'h0C, 5'h04, 6'h01, 1'b1, st, fw);
    run(OP_LOAD_MULTIPLE, 1'b0, 3'h0, 5'h00, 5'h00, 5'h16, 6'h02, 1'b0, st, fw);
    chk("load stalls", 32'h4, 32'(st));
    #1;
    chk("load dst locks", 32'h00C0_0000, dstLockOut & 32'h00C0_0000);
    repeat (20) @(posedge clk_sys);
    // compare then flag transfer
    run(OP_SINGLE_COMPARE, 1'b0, 3'h0, 5'h01, 5'h02, 5'h00, 6'h01, 1'b1, st, fw);
    run(OP_MOVE_FLAGS_TO_HOST, 1'b0, 3'h0, 5'h00, 5'h00, 5'h00, 6'h01, 1'b0, st, fw);
    chk("flag transfer stalls", 32'(CMP_EXEC_CYCLES) - 1, 32'(st));
    for (int t = 1; t <= 3; t++) begin
      #1;
      chk("hostFlagsValid", 32'(t == 32'(FLAG_DELIVER_CYCLES)), 32'(hostFlagsValid));
      if (t == 2) chk("hostFlags", 32'hA, 32'(hostFlags));
      @(posedge clk_sys);
    end
    repeat (8) @(posedge clk_sys);
    // dependent add waits for the last load writeback pair
    run(OP_LOAD_MULTIPLE, 1'b0, 3'h0, 5'h00, 5'h00, 5'h08, 6'h08, 1'b1, st, fw);
    run(OP_SINGLE_ADD, 1'b0, 3'h0, 5'h02, 5'h0F, 5'h01, 6'h01, 1'b0, st, fw);
    chk("add stalls", 32'h6, 32'(st));
    chk("forwardHit", 32'h1, 32'(fw));
    #1;
    chk("load dst clear", 32'h0, dstLockOut & 32'h0000_FF00);
    repeat (10) @(posedge clk_sys);
    // frozen clock enable holds the release schedule; it resumes where it stopped
    run(OP_DOUBLE_ADD, 1'b0, 3'h1, 5'h08, 5'h0C, 5'h04, 6'h01, 1'b0, st, fw);
    clkEn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("frozen srcLockOut", dbl(4'h8) | dbl(4'h9) | dbl(4'hC) | dbl(4'hD), srcLockOut);
    @(posedge clk_sys);
    clkEn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk("thawed srcLockOut", dbl(4'h9) | dbl(4'hD), srcLockOut);
    repeat (10) @(posedge clk_sys);
    summarize();
  end
endmodule : dpsb_scoreboard_test
`default_nettype wire
